// ---- shc_pkg.sv ----
package shc_pkg;
  // ----------------------------------------
  // Timing
  // ----------------------------------------
  localparam int unsigned CLK_PERIOD_NS = 8;
  localparam int unsigned SCL_QTR_NS = 2500;
  localparam int unsigned SCL_QTR_CYC =
    (SCL_QTR_NS / CLK_PERIOD_NS) < 1 ? 1 : (SCL_QTR_NS / CLK_PERIOD_NS);
  // ----------------------------------------
  // Register indices, byte address = 4 * index
  // ----------------------------------------
  localparam logic [3:0] IDX_STATUS = 4'h0;
  localparam logic [3:0] IDX_CONTROL = 4'h2;
  localparam logic [3:0] IDX_COMMAND = 4'h3;
  localparam logic [3:0] IDX_ADDRESS = 4'h4;
  localparam logic [3:0] IDX_DATA0 = 4'h5;
  localparam logic [3:0] IDX_DATA1 = 4'h6;
  localparam logic [3:0] IDX_BLOCK = 4'h7;
  localparam logic [3:0] IDX_CONFIG = 4'h8;
  // ----------------------------------------
  // Field positions and reset values
  // ----------------------------------------
  localparam int unsigned CTL_IE = 0;
  localparam int unsigned CTL_KILL = 1;
  localparam int unsigned CTL_PROT_LO = 2;
  localparam int unsigned CTL_START = 6;
  localparam int unsigned STS_BUSY = 0;
  localparam int unsigned STS_COMPLETION_FLAG = 1;
  localparam int unsigned STS_DEVERR = 2;
  localparam int unsigned STS_BUSERR = 3;
  localparam int unsigned STS_FAILED = 4;
  localparam int unsigned CFG_ROUTE = 0;
  localparam logic [7:0] REG_RST = 8'h00;
  localparam int unsigned BLK_DEPTH = 32;
  localparam logic [5:0] BLK_MAX = 6'h20;
  // ----------------------------------------
  // Protocol codes and bus answers
  // ----------------------------------------
  localparam logic [2:0] PROT_QUICK = 3'h0;
  localparam logic [2:0] PROT_BYTE = 3'h1;
  localparam logic [2:0] PROT_BDATA = 3'h2;
  localparam logic [2:0] PROT_WORD = 3'h3;
  localparam logic [2:0] PROT_BLOCK = 3'h5;
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;
  // ----------------------------------------
  // Types
  // ----------------------------------------
  typedef enum logic [2:0] {
    S_IDLE = 3'h0, S_NEXT = 3'h1, S_START = 3'h2, S_BIT = 3'h3, S_STOP = 3'h4, S_FIN = 3'h5
  } shc_state_e;
  typedef enum logic [3:0] {
    K_ADDR = 4'h0, K_CMD = 4'h1, K_D0W = 4'h2, K_D1W = 4'h3, K_CNTW = 4'h4, K_BLKW = 4'h5,
    K_RST = 4'h6, K_ADDRR = 4'h7, K_RD0 = 4'h8, K_RD1 = 4'h9, K_RCNT = 4'ha, K_RBLK = 4'hb,
    K_STOP = 4'hc
  } shc_kind_e;
endpackage

// ---- shc_top.sv ----
`timescale 1ns/1ns
// How it works
// - Protocol field: 000 quick, 001 byte, 010 byte-data, 011 word, 101 block.
// - Kill aborts the running transaction, sets failed and raises the interrupt.
// - Control bit 0 enables the completion interrupt on IRQ or SMI.
// - Setup registers first; the transaction runs only when start is written.
// - Completion raises the enabled interrupt, routed to IRQ or SMI by config.
// - Errors and kill also raise the interrupt.
// - A completion flag is set when a transaction finishes without error, for polling.
// - Start is ignored while any interrupt status flag is still set.
// - Block protocols keep data in a 32-byte array behind an index pointer.
// - Reading the control register resets the index pointer to zero.
// - Each block data register access advances the index pointer.
// - Block read: slave gives length; count lands in data zero, bytes in array.
// - Controller array accesses in a transaction start at location 0.
// - Registers are overwritten by a new transaction; save them beforehand.
// - Quick, send/receive byte, write/read byte or word, block read/write.
// - Direction comes from bit 0 of the slave address register.
// - Status flags are set by hardware, cleared by writing one.
// - Busy reads one while a command is processed, zero otherwise.
// - Start always reads zero; writing zero does nothing.
module shc_top
  import shc_pkg::*;
#(
  parameter int unsigned QTR_CYC = SCL_QTR_CYC
) (
  input logic aclk,
  input logic aresetn,
  input logic [7:0] s_axi_awaddr,
  input logic s_axi_awvalid,
  output logic s_axi_awready,
  input logic [31:0] s_axi_wdata,
  input logic [3:0] s_axi_wstrb,
  input logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input logic s_axi_bready,
  input logic [7:0] s_axi_araddr,
  input logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input logic s_axi_rready,
  input logic scl_i,
  output logic scl_o,
  output logic scl_oe,
  input logic sda_i,
  output logic sda_o,
  output logic sda_oe,
  output logic irq_output,
  output logic sys_mgmt_interrupt_n
);
  localparam logic [15:0] QTR_M1 = 16'(QTR_CYC - 1);

  logic [1:0] scl_sync_ff, sda_sync_ff;
  logic aw_full_ff, w_full_ff, awready_ff, wready_ff, bvalid_ff, arready_ff, rvalid_ff;
  logic [7:0] awaddr_ff, wbyte_ff;
  logic wstrb0_ff;
  logic [1:0] bresp_ff, rresp_ff;
  logic [7:0] rdata_ff;
  logic ie_ff, kill_ff, route_ff, busy_ff;
  logic completion_flag_ff, deverr_ff, buserr_ff, failed_ff;
  logic [2:0] prot_ff;
  logic [7:0] cmd_ff, saddr_ff, d0_ff, d1_ff;
  logic [4:0] ptr_ff;
  logic [7:0] blk_mem [BLK_DEPTH];
  shc_state_e state_ff;
  logic [1:0] phase_ff;
  logic [15:0] div_ff;
  logic [2:0] step_ff;
  logic [3:0] bit_ff;
  logic [8:0] sh_ff;
  logic [7:0] rx_ff;
  logic ack_ff, err_dev_ff, err_bus_ff;
  logic [5:0] bidx_ff, cnt_ff;
  logic scl_oe_ff, sda_oe_ff, low_ff, irq_ff, smi_n_ff;

  // ----------------------------------------
  // Pin synchronisers
  // ----------------------------------------
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      scl_sync_ff <= 2'h3;
      sda_sync_ff <= 2'h3;
    end else begin
      scl_sync_ff <= {scl_sync_ff[0], scl_i};
      sda_sync_ff <= {sda_sync_ff[0], sda_i};
    end
  end
  wire scl_s = scl_sync_ff[1];
  wire sda_s = sda_sync_ff[1];

  // ----------------------------------------
  // Bus write channel
  // ----------------------------------------
  wire aw_take = s_axi_awvalid & awready_ff;
  wire w_take = s_axi_wvalid & wready_ff;
  wire wr_do = aw_full_ff & w_full_ff & ~bvalid_ff;
  wire nxt_aw_full = (aw_full_ff & ~wr_do) | aw_take;
  wire nxt_w_full = (w_full_ff & ~wr_do) | w_take;
  wire [3:0] wr_idx = awaddr_ff[5:2];
  wire wr_hit = (awaddr_ff[7:6] == 2'h0) && (awaddr_ff[1:0] == 2'h0) &&
    (wr_idx <= IDX_CONFIG) && (wr_idx != 4'h1);
  wire wr_en = wr_do & wr_hit & wstrb0_ff;
  wire wr_sts = wr_en && (wr_idx == IDX_STATUS);
  wire wr_ctl = wr_en && (wr_idx == IDX_CONTROL);
  wire wr_blk = wr_en && (wr_idx == IDX_BLOCK);

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_full_ff <= 1'b0;
      w_full_ff <= 1'b0;
      awready_ff <= 1'b0;
      wready_ff <= 1'b0;
      bvalid_ff <= 1'b0;
      bresp_ff <= RESP_OKAY;
      awaddr_ff <= REG_RST;
      wbyte_ff <= REG_RST;
      wstrb0_ff <= 1'b0;
    end else begin
      aw_full_ff <= nxt_aw_full;
      w_full_ff <= nxt_w_full;
      awready_ff <= ~nxt_aw_full;
      wready_ff <= ~nxt_w_full;
      if (aw_take) begin
        awaddr_ff <= s_axi_awaddr;
      end
      if (w_take) begin
        wbyte_ff <= s_axi_wdata[7:0];
        wstrb0_ff <= s_axi_wstrb[0];
      end
      if (wr_do) begin
        bvalid_ff <= 1'b1;
        bresp_ff <= wr_hit ? RESP_OKAY : RESP_SLVERR;
      end else if (s_axi_bready) begin
        bvalid_ff <= 1'b0;
      end
    end
  end

  // ----------------------------------------
  // Bus read channel
  // ----------------------------------------
  wire rd_take = s_axi_arvalid & arready_ff;
  wire nxt_rvalid = (rvalid_ff & ~s_axi_rready) | rd_take;
  wire [3:0] rd_idx = s_axi_araddr[5:2];
  logic [7:0] rd_val;
  logic rd_hit;
  always_comb begin
    rd_val = 8'h00;
    rd_hit = (s_axi_araddr[7:6] == 2'h0) && (s_axi_araddr[1:0] == 2'h0);
    case (rd_idx)
      IDX_STATUS: rd_val = {3'h0, failed_ff, buserr_ff, deverr_ff, completion_flag_ff, busy_ff};
      IDX_CONTROL: rd_val = {3'h0, prot_ff, kill_ff, ie_ff};
      IDX_COMMAND: rd_val = cmd_ff;
      IDX_ADDRESS: rd_val = saddr_ff;
      IDX_DATA0: rd_val = d0_ff;
      IDX_DATA1: rd_val = d1_ff;
      IDX_BLOCK: rd_val = blk_mem[ptr_ff];
      IDX_CONFIG: rd_val = {7'h00, route_ff};
      default: rd_hit = 1'b0;
    endcase
  end
  wire rd_ok = rd_take & rd_hit;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      arready_ff <= 1'b0;
      rvalid_ff <= 1'b0;
      rdata_ff <= REG_RST;
      rresp_ff <= RESP_OKAY;
    end else begin
      arready_ff <= ~nxt_rvalid;
      rvalid_ff <= nxt_rvalid;
      if (rd_take) begin
        rdata_ff <= rd_hit ? rd_val : 8'h00;
        rresp_ff <= rd_hit ? RESP_OKAY : RESP_SLVERR;
      end
    end
  end

  // ----------------------------------------
  // Engine decode
  // ----------------------------------------
  function automatic shc_kind_e kind_of(input logic [2:0] p, input logic r,
                                        input logic [2:0] s);
    shc_kind_e k;
    k = K_STOP;
    case (s)
      3'h0: k = (p == PROT_QUICK || p == PROT_BYTE || p == PROT_BDATA || p == PROT_WORD ||
                 p == PROT_BLOCK) ? K_ADDR : K_STOP;
      3'h1: k = (p == PROT_QUICK) ? K_STOP : (p == PROT_BYTE && r) ? K_RD0 : K_CMD;
      3'h2: k = (p == PROT_QUICK || p == PROT_BYTE) ? K_STOP : r ? K_RST :
                (p == PROT_BLOCK) ? K_CNTW : K_D0W;
      3'h3: k = (p == PROT_QUICK || p == PROT_BYTE) ? K_STOP : r ? K_ADDRR :
                (p == PROT_WORD) ? K_D1W : (p == PROT_BLOCK) ? K_BLKW : K_STOP;
      3'h4: k = (!r || p == PROT_QUICK || p == PROT_BYTE) ? K_STOP :
                (p == PROT_BLOCK) ? K_RCNT : K_RD0;
      3'h5: k = (r && p == PROT_WORD) ? K_RD1 : (r && p == PROT_BLOCK) ? K_RBLK : K_STOP;
      default: k = K_STOP;
    endcase
    return k;
  endfunction

  function automatic logic [5:0] clamp(input logic [7:0] v);
    return (v > 8'(BLK_MAX)) ? BLK_MAX : v[5:0];
  endfunction

  wire rw = saddr_ff[0];
  wire shc_kind_e kind = kind_of(prot_ff, rw, step_ff);
  wire is_rd = (kind == K_RD0) || (kind == K_RD1) || (kind == K_RCNT) || (kind == K_RBLK);
  wire [5:0] bidx_inc = bidx_ff + 6'h01;
  wire last_rd = (kind == K_RD1) || (kind == K_RD0 && prot_ff != PROT_WORD) ||
    (kind == K_RBLK && bidx_inc >= cnt_ff);
  logic [7:0] tx;
  always_comb begin
    case (kind)
      K_ADDR: tx = {saddr_ff[7:1], (prot_ff == PROT_QUICK || prot_ff == PROT_BYTE) & rw};
      K_CMD: tx = cmd_ff;
      K_D0W: tx = d0_ff;
      K_CNTW: tx = d0_ff;
      K_D1W: tx = d1_ff;
      K_BLKW: tx = blk_mem[bidx_ff[4:0]];
      K_ADDRR: tx = {saddr_ff[7:1], 1'b1};
      default: tx = 8'hff;
    endcase
  end
  wire stall = (phase_ff == 2'h2) && !scl_s;
  wire ph_tick = (div_ff == QTR_M1) && !stall;
  wire smp = (state_ff == S_BIT) && ph_tick && (phase_ff == 2'h2);
  wire byte_end = (state_ff == S_BIT) && ph_tick && (phase_ff == 2'h3) && (bit_ff == 4'h8);
  wire nack = byte_end && !is_rd && ack_ff;
  wire coll = smp && !is_rd && (bit_ff < 4'h8) && sh_ff[8] && !sda_s;
  wire any_flag = completion_flag_ff | deverr_ff | buserr_ff | failed_ff;
  wire start_req = wr_ctl && wbyte_ff[CTL_START] && !wbyte_ff[CTL_KILL] && !busy_ff &&
    !any_flag && (state_ff == S_IDLE);
  wire [2:0] wprot = wbyte_ff[CTL_PROT_LO +: 3];
  wire prot_ok = (wprot != 3'h4) && (wprot != 3'h6) && (wprot != 3'h7);
  wire fin = (state_ff == S_FIN);
  wire killing = kill_ff && (state_ff != S_IDLE);

  // ----------------------------------------
  // Control and data registers
  // ----------------------------------------
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      ie_ff <= 1'b0;
      kill_ff <= 1'b0;
      prot_ff <= 3'h0;
      route_ff <= 1'b0;
      cmd_ff <= REG_RST;
      saddr_ff <= REG_RST;
      d0_ff <= REG_RST;
      d1_ff <= REG_RST;
    end else begin
      if (wr_ctl) begin
        ie_ff <= wbyte_ff[CTL_IE];
        kill_ff <= wbyte_ff[CTL_KILL];
        prot_ff <= wprot;
      end
      if (wr_en && wr_idx == IDX_CONFIG) begin
        route_ff <= wbyte_ff[CFG_ROUTE];
      end
      if (wr_en && wr_idx == IDX_COMMAND) begin
        cmd_ff <= wbyte_ff;
      end
      if (wr_en && wr_idx == IDX_ADDRESS) begin
        saddr_ff <= wbyte_ff;
      end
      if (byte_end && (kind == K_RD0 || kind == K_RCNT)) begin
        d0_ff <= rx_ff;
      end else if (wr_en && wr_idx == IDX_DATA0) begin
        d0_ff <= wbyte_ff;
      end
      if (byte_end && kind == K_RD1) begin
        d1_ff <= rx_ff;
      end else if (wr_en && wr_idx == IDX_DATA1) begin
        d1_ff <= wbyte_ff;
      end
    end
  end

  // ----------------------------------------
  // Block array and index pointer
  // ----------------------------------------
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      ptr_ff <= 5'h00;
    end else if (rd_ok && rd_idx == IDX_CONTROL) begin
      ptr_ff <= 5'h00;
    end else if (wr_blk || (rd_ok && rd_idx == IDX_BLOCK)) begin
      ptr_ff <= ptr_ff + 5'h01;
    end
  end

  always_ff @(posedge aclk) begin
    if (byte_end && kind == K_RBLK) begin
      blk_mem[bidx_ff[4:0]] <= rx_ff;
    end else if (wr_blk) begin
      blk_mem[ptr_ff] <= wbyte_ff;
    end
  end

  // ----------------------------------------
  // Status flags
  // ----------------------------------------
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      busy_ff <= 1'b0;
      completion_flag_ff <= 1'b0;
      deverr_ff <= 1'b0;
      buserr_ff <= 1'b0;
      failed_ff <= 1'b0;
    end else begin
      if (start_req) begin
        busy_ff <= 1'b1;
      end else if (fin || killing) begin
        busy_ff <= 1'b0;
      end
      if (fin && !err_dev_ff && !err_bus_ff) begin
        completion_flag_ff <= 1'b1;
      end else if (wr_sts && wbyte_ff[STS_COMPLETION_FLAG]) begin
        completion_flag_ff <= 1'b0;
      end
      if (fin && err_dev_ff) begin
        deverr_ff <= 1'b1;
      end else if (wr_sts && wbyte_ff[STS_DEVERR]) begin
        deverr_ff <= 1'b0;
      end
      if (fin && err_bus_ff) begin
        buserr_ff <= 1'b1;
      end else if (wr_sts && wbyte_ff[STS_BUSERR]) begin
        buserr_ff <= 1'b0;
      end
      if (wr_ctl && wbyte_ff[CTL_KILL] && !kill_ff) begin
        failed_ff <= 1'b1;
      end else if (wr_sts && wbyte_ff[STS_FAILED]) begin
        failed_ff <= 1'b0;
      end
    end
  end

  // ----------------------------------------
  // Serial engine
  // ----------------------------------------
  always_ff @(posedge aclk) begin
    if (!aresetn || state_ff == S_IDLE || state_ff == S_NEXT || fin || ph_tick) begin
      div_ff <= 16'h0000;
    end else if (!stall) begin
      div_ff <= div_ff + 16'h0001;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      state_ff <= S_IDLE;
      phase_ff <= 2'h0;
      step_ff <= 3'h0;
      bit_ff <= 4'h0;
      sh_ff <= 9'h1ff;
      rx_ff <= 8'h00;
      ack_ff <= 1'b0;
      err_dev_ff <= 1'b0;
      err_bus_ff <= 1'b0;
      bidx_ff <= 6'h00;
      cnt_ff <= 6'h00;
    end else if (killing) begin
      state_ff <= S_IDLE;
    end else begin
      case (state_ff)
        S_IDLE: begin
          if (start_req) begin
            err_dev_ff <= !prot_ok;
            err_bus_ff <= 1'b0;
            step_ff <= 3'h0;
            bidx_ff <= 6'h00;
            phase_ff <= 2'h0;
            state_ff <= prot_ok ? S_START : S_FIN;
          end
        end
        S_NEXT: begin
          bit_ff <= 4'h0;
          phase_ff <= 2'h0;
          if (kind == K_STOP) begin
            state_ff <= S_STOP;
          end else if (kind == K_RST) begin
            state_ff <= S_START;
          end else begin
            sh_ff <= {tx, is_rd ? last_rd : 1'b1};
            state_ff <= S_BIT;
          end
        end
        S_START: begin
          if (ph_tick) begin
            phase_ff <= phase_ff + 2'h1;
            if (phase_ff == 2'h3) begin
              state_ff <= S_NEXT;
              if (kind == K_RST) begin
                step_ff <= step_ff + 3'h1;
              end
            end
          end
        end
        S_BIT: begin
          if (coll) begin
            err_bus_ff <= 1'b1;
            state_ff <= S_FIN;
          end else if (ph_tick) begin
            phase_ff <= phase_ff + 2'h1;
            if (smp && bit_ff == 4'h8) begin
              ack_ff <= sda_s;
            end else if (smp) begin
              rx_ff <= {rx_ff[6:0], sda_s};
            end
            if (phase_ff == 2'h3) begin
              sh_ff <= {sh_ff[7:0], 1'b1};
              bit_ff <= bit_ff + 4'h1;
            end
            if (nack) begin
              err_dev_ff <= 1'b1;
              state_ff <= S_STOP;
            end else if (byte_end) begin
              state_ff <= S_NEXT;
              case (kind)
                K_BLKW, K_RBLK: begin
                  bidx_ff <= bidx_inc;
                  step_ff <= (bidx_inc >= cnt_ff) ? step_ff + 3'h1 : step_ff;
                end
                K_CNTW: begin
                  cnt_ff <= clamp(d0_ff);
                  step_ff <= (clamp(d0_ff) == 6'h00) ? step_ff + 3'h2 : step_ff + 3'h1;
                end
                K_RCNT: begin
                  cnt_ff <= clamp(rx_ff);
                  step_ff <= (clamp(rx_ff) == 6'h00) ? step_ff + 3'h2 : step_ff + 3'h1;
                end
                default: step_ff <= step_ff + 3'h1;
              endcase
            end
          end
        end
        S_STOP: begin
          if (ph_tick) begin
            phase_ff <= phase_ff + 2'h1;
            if (phase_ff == 2'h3) begin
              state_ff <= S_FIN;
            end
          end
        end
        S_FIN: state_ff <= S_IDLE;
        default: state_ff <= S_IDLE;
      endcase
    end
  end

  // ----------------------------------------
  // Pin drivers and interrupt lines
  // ----------------------------------------
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      scl_oe_ff <= 1'b0;
      sda_oe_ff <= 1'b0;
      low_ff <= 1'b0;
      irq_ff <= 1'b0;
      smi_n_ff <= 1'b1;
    end else begin
      low_ff <= 1'b0;
      case (state_ff)
        S_START: begin
          scl_oe_ff <= (phase_ff == 2'h0) || (phase_ff == 2'h3);
          sda_oe_ff <= phase_ff[1];
        end
        S_BIT: begin
          scl_oe_ff <= (phase_ff == 2'h0) || (phase_ff == 2'h3);
          sda_oe_ff <= ~sh_ff[8];
        end
        S_STOP: begin
          scl_oe_ff <= (phase_ff == 2'h0);
          sda_oe_ff <= !phase_ff[1];
        end
        S_NEXT: begin
          scl_oe_ff <= 1'b1;
          sda_oe_ff <= sda_oe_ff;
        end
        default: begin
          scl_oe_ff <= 1'b0;
          sda_oe_ff <= 1'b0;
        end
      endcase
      irq_ff <= ((ie_ff & (completion_flag_ff | deverr_ff | buserr_ff)) | failed_ff) & ~route_ff;
      smi_n_ff <= ~(((ie_ff & (completion_flag_ff | deverr_ff | buserr_ff)) | failed_ff) & route_ff);
    end
  end

  assign s_axi_awready = awready_ff;
  assign s_axi_wready = wready_ff;
  assign s_axi_bresp = bresp_ff;
  assign s_axi_bvalid = bvalid_ff;
  assign s_axi_arready = arready_ff;
  assign s_axi_rdata = {24'h000000, rdata_ff};
  assign s_axi_rresp = rresp_ff;
  assign s_axi_rvalid = rvalid_ff;
  assign scl_o = low_ff;
  assign sda_o = low_ff;
  assign scl_oe = scl_oe_ff;
  assign sda_oe = sda_oe_ff;
  assign irq_output = irq_ff;
  assign sys_mgmt_interrupt_n = smi_n_ff;
endmodule // shc_top

// ---- shc_checker.sv ----
`timescale 1ns/1ns
module shc_checker
  import shc_pkg::*;
#(parameter int unsigned QTR_CYC = SCL_QTR_CYC) (
  input logic aclk,
  input logic aresetn,
  input logic [7:0] s_axi_awaddr,
  input logic s_axi_awvalid,
  input logic s_axi_awready,
  input logic [31:0] s_axi_wdata,
  input logic s_axi_wvalid,
  input logic s_axi_wready,
  input logic s_axi_bvalid,
  input logic [7:0] s_axi_araddr,
  input logic s_axi_arvalid,
  input logic s_axi_arready,
  input logic [31:0] s_axi_rdata,
  input logic s_axi_rvalid,
  input logic scl_oe,
  input logic sda_oe,
  input logic irq_output,
  input logic sys_mgmt_interrupt_n
);
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);
  // ----
  // Captured bus fields
  // ----
  logic [7:0] wa_ff, wd_ff, ra_ff;
  logic kp_ff, st_ff;
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      wa_ff <= 8'h00;
      wd_ff <= 8'h00;
      ra_ff <= 8'h00;
      kp_ff <= 1'h0;
      st_ff <= 1'h0;
    end else begin
      if (s_axi_awvalid && s_axi_awready) wa_ff <= s_axi_awaddr;
      if (s_axi_wvalid && s_axi_wready) wd_ff <= s_axi_wdata[7:0];
      if (s_axi_arvalid && s_axi_arready) ra_ff <= s_axi_araddr;
      if (s_axi_bvalid && wa_ff == 8'h08) kp_ff <= wd_ff[CTL_KILL];
      if (s_axi_wvalid && s_axi_wready && s_axi_wdata[CTL_START]) st_ff <= 1'h1;
    end
  end
  sequence kill_wr;
    $rose(s_axi_bvalid) && wa_ff == 8'h08 && wd_ff[CTL_KILL] && !kp_ff;
  endsequence
  a_start_zero: assert property (
    s_axi_rvalid && ra_ff == 8'h08 |-> !s_axi_rdata[CTL_START]) else $error("start read one");
  a_busy_idle: assert property (
    s_axi_rvalid && ra_ff == 8'h00 && !st_ff |-> !s_axi_rdata[STS_BUSY]) else $error("busy early");
  a_lines_quiet: assert property (
    !st_ff |-> !scl_oe && !sda_oe) else $error("bus driven before start");
  a_kill_irq: assert property (
    kill_wr |-> ##[0:3] (irq_output || !sys_mgmt_interrupt_n)) else $error("kill no interrupt");
  a_kill_free: assert property (
    kill_wr |-> ##[0:3] (!scl_oe && !sda_oe)) else $error("kill lines held");
  a_irq_route: assert property (
    !(irq_output && !sys_mgmt_interrupt_n)) else $error("interrupt on both outputs");
  a_rd_answer: assert property (
    s_axi_arvalid && s_axi_arready |=> s_axi_rvalid && !s_axi_arready) else $error("read late");
  a_wr_answer: assert property (
    s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready |-> ##2 s_axi_bvalid)
    else $error("write late");
endmodule // shc_checker
bind shc_top shc_checker #(.QTR_CYC(QTR_CYC)) u_chk (.aclk(aclk), .aresetn(aresetn),
  .s_axi_awaddr(s_axi_awaddr), .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready),
  .s_axi_wdata(s_axi_wdata), .s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready),
  .s_axi_bvalid(s_axi_bvalid), .s_axi_araddr(s_axi_araddr), .s_axi_arvalid(s_axi_arvalid),
  .s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata), .s_axi_rvalid(s_axi_rvalid),
  .scl_oe(scl_oe), .sda_oe(sda_oe), .irq_output(irq_output),
  .sys_mgmt_interrupt_n(sys_mgmt_interrupt_n));

// ---- shc_slave_model.sv ----
`timescale 1ns/1ns
module shc_slave_model (
  input wire logic scl,
  input wire logic sda,
  output logic sda_oe
);
  // ----
  // Byte framing and answers
  // ----
  int n = -1;
  int i = 0;
  logic rd = 1'h0;
  logic ad = 1'h0;
  logic [7:0] sh = 8'h00;
  logic [7:0] b;
  initial sda_oe = 1'h0;
  always @(negedge sda) begin
    if (scl === 1'h1) begin
      n = -1;
      i = 0;
      ad = 1'h1;
      rd = 1'h0;
    end
  end
  always @(posedge scl) begin
    if (n >= 0 && n < 8) sh = {sh[6:0], sda};
  end
  always @(negedge scl) begin
    n = (n == 8) ? 0 : n + 1;
    b = 8'(3 + i);
    if (n == 8) begin
      sda_oe = ad || !rd;
      i = i + (rd ? 1 : 0);
      rd = ad ? sh[0] : rd;
      ad = 1'h0;
    end else begin
      sda_oe = rd && !b[7 - n];
    end
  end
endmodule // shc_slave_model

// ---- smbus_host_controller_tb.sv ----
`timescale 1ns/1ns
module smbus_host_controller_tb;
  import shc_pkg::*;
  localparam logic [7:0] EX [4] = '{8'h04, 8'h05, 8'h06, 8'h44};
  logic aclk = 1'h0, aresetn = 1'h0, awv = 1'h0, wv = 1'h0, br = 1'h0, arv = 1'h0, rr = 1'h0;
  logic [7:0] awaddr = 8'h00, araddr = 8'h00;
  logic [31:0] wdata = 32'h0, rdata;
  logic awr, wrd, bv, arr, rv, scl_o, scl_oe, sda_o, sda_oe, irq, smi_n, s_oe;
  logic [1:0] bresp, rresp, wresp;
  int error_cnt = 0;
  int checks = 0;
  wire scl = !scl_oe;
  wire sda = !(sda_oe || s_oe);
  always #4 aclk = ~aclk;
  shc_top #(.QTR_CYC(4)) DUT (
    .aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(awaddr), .s_axi_awvalid(awv),
    .s_axi_awready(awr), .s_axi_wdata(wdata), .s_axi_wstrb(4'hf), .s_axi_wvalid(wv),
    .s_axi_wready(wrd), .s_axi_bresp(bresp), .s_axi_bvalid(bv), .s_axi_bready(br),
    .s_axi_araddr(araddr), .s_axi_arvalid(arv), .s_axi_arready(arr), .s_axi_rdata(rdata),
    .s_axi_rresp(rresp), .s_axi_rvalid(rv), .s_axi_rready(rr), .scl_i(scl), .scl_o(scl_o),
    .scl_oe(scl_oe), .sda_i(sda), .sda_o(sda_o), .sda_oe(sda_oe), .irq_output(irq),
    .sys_mgmt_interrupt_n(smi_n));
  shc_slave_model u_slv (.scl(scl), .sda(sda), .sda_oe(s_oe));
  // ----
  // Bus tasks
  // ----
  task automatic summarize();
    if (error_cnt == 0 && checks > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask
  task automatic tmo();
    error_cnt++;
    summarize();
  endtask
  task automatic chk(input logic [31:0] g, input logic [31:0] e);
    checks++;
    if (g !== e) begin
      error_cnt++;
      $display("unexpected at %0t: got %h expected %h", $time, g, e);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    logic ka, kw, kb;
    kb = 1'h0;
    @(posedge aclk);
    awaddr <= a;
    wdata <= {24'h0, d};
    awv <= 1'h1;
    wv <= 1'h1;
    br <= 1'h1;
    for (int n = 0; n < 40 && !kb; n++) begin
      @(negedge aclk);
      ka = awv && awr;
      kw = wv && wrd;
      kb = bv === 1'h1;
      wresp = bresp;
      @(posedge aclk);
      if (ka) awv <= 1'h0;
      if (kw) wv <= 1'h0;
      if (kb) br <= 1'h0;
    end
    if (!kb) tmo();
  endtask
  task automatic rd(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
    logic ka, kb;
    kb = 1'h0;
    @(posedge aclk);
    araddr <= a;
    arv <= 1'h1;
    rr <= 1'h1;
    for (int n = 0; n < 40 && !kb; n++) begin
      @(negedge aclk);
      ka = arv && arr;
      kb = rv === 1'h1;
      d = rdata;
      r = rresp;
      @(posedge aclk);
      if (ka) arv <= 1'h0;
      if (kb) rr <= 1'h0;
    end
    if (!kb) tmo();
  endtask
  task automatic wait_done(output logic [31:0] s);
    logic [1:0] r;
    s = 32'h0;
    for (int n = 0; n < 3000 && s[4:1] === 4'h0; n++) rd(8'h00, s, r);
    if (s[4:1] === 4'h0) tmo();
    @(negedge aclk);
  endtask
  initial begin
    logic [31:0] d;
    logic [1:0] r;
    repeat (3) @(posedge aclk);
    aresetn <= 1'h1;
    rd(8'h00, d, r);
    chk(d, 32'h0);
    rd(8'h04, d, r);
    chk(r, RESP_SLVERR);
    wr(8'h04, 8'h01);
    chk(wresp, RESP_SLVERR);
    wr(8'h1c, 8'h5a);
    chk(wresp, RESP_OKAY);
    for (int k = 0; k < 8; k++) begin
      wr(8'h10, 8'ha0);
      wr(8'h14, 8'h01);
      wr(8'h08, 8'(8'h41 | (k << 2)));
      wait_done(d);
      chk(d, (k == 4 || k > 5) ? 32'h4 : 32'h2);
      chk(irq, 1'h1);
      wr(8'h08, 8'h41);
      rd(8'h00, d, r);
      chk(d, (k == 4 || k > 5) ? 32'h4 : 32'h2);
      wr(8'h00, 8'h1e);
    end
    wr(8'h20, 8'h01);
    rd(8'h08, d, r);
    chk(d, 32'h01);
    for (int k = 0; k < 4; k++) wr(8'h1c, 8'(8'h11 * (k + 1)));
    rd(8'h08, d, r);
    for (int k = 0; k < 2; k++) begin
      rd(8'h1c, d, r);
      chk(d, 32'(8'h11 * (k + 1)));
    end
    wr(8'h10, 8'ha1);
    wr(8'h08, 8'h55);
    wait_done(d);
    chk(d, 32'h2);
    chk({irq, smi_n}, 2'h0);
    rd(8'h14, d, r);
    chk(d, 32'h3);
    rd(8'h08, d, r);
    for (int k = 0; k < 4; k++) begin
      rd(8'h1c, d, r);
      chk(d, {24'h0, EX[k]});
    end
    wr(8'h00, 8'h1e);
    wr(8'h10, 8'ha0);
    wr(8'h08, 8'h4d);
    wr(8'h08, 8'h0e);
    rd(8'h00, d, r);
    chk(d, 32'h10);
    @(negedge aclk);
    chk({smi_n, scl_oe, sda_oe, scl_o, sda_o}, 5'h0);
    wr(8'h08, 8'h00);
    wr(8'h00, 8'h1e);
    @(negedge aclk);
    chk(smi_n, 1'h1);
    summarize();
  end
endmodule // smbus_host_controller_tb
